// >>> design/pcg_gate_bank.sv
`timescale 1ns/1ps

module pcg_gate_bank import pcg_pkg::*; #(
    parameter int N = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] req,
    output logic [N-1:0] gate_on
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (N < 1) begin : g_bad_n
        $error("pcg_gate_bank needs at least one gate");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [N-1:0] on;  // Enable in force per peripheral
    } pcg_bank_state_t;

    pcg_bank_state_t st;       // Current state
    pcg_bank_state_t next_st;  // Next state

    // Next enable is simply the request
    always_comb begin
        next_st = st;
        next_st.on = req;
    end

    // Enables change only on the clock edge, so a gated clock sees
    // whole cycles; during reset every peripheral clock runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.on <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign gate_on = st.on;

endmodule : pcg_gate_bank

// >>> design/pcg_map.svh
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PCG_OFF_ENABLE_A 32'h0000_0000
`define PCG_OFF_ENABLE_B 32'h0000_0004
`define PCG_OFF_LIVE 32'h0000_0008

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCG_RST_ENABLE_A 32'h0001_0001
`define PCG_RST_ENABLE_B 32'hf000_0000

// ----------------------------------------------------------------
// Enable bit positions, register A
// ----------------------------------------------------------------
`define PCG_BIT_TIMER_D 18
`define PCG_BIT_USB_DEVICE 17
`define PCG_BIT_CONVERTER 16
`define PCG_BIT_DMA 15
`define PCG_BIT_SYNC_SERIAL 14
`define PCG_BIT_SERIAL0 13
`define PCG_BIT_I2C0 12
`define PCG_BIT_TIMER16 11
`define PCG_BIT_TIMER_CH4_6 10
`define PCG_BIT_TIMER_CH0_3 9
`define PCG_BIT_PORT_J 8
`define PCG_BIT_PORT_H 7

// ----------------------------------------------------------------
// Enable bit positions, register B
// ----------------------------------------------------------------
`define PCG_BIT_I2C1 31
`define PCG_BIT_WATCHDOG 30
`define PCG_BIT_SERIAL1 29
`define PCG_BIT_TIMER_CH7 28

// ----------------------------------------------------------------
// Bus response codes
// ----------------------------------------------------------------
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2

`endif

// >>> design/pcg_pkg.sv
package pcg_pkg;

    // ------------------------------------------------------------
    // Write channel progress, Gray along idle-addr-resp-data
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        pcg_wr_idle = 2'h0,
        pcg_wr_addr = 2'h1,
        pcg_wr_resp = 2'h3,
        pcg_wr_data = 2'h2
    } pcg_wr_t;

    // Read channel progress
    typedef enum logic {
        pcg_rd_idle = 1'h0,
        pcg_rd_data = 1'h1
    } pcg_rd_t;

    // Decoded register target
    typedef enum logic [1:0] {
        pcg_sel_a = 2'h0,
        pcg_sel_b = 2'h1,
        pcg_sel_live = 2'h2,
        pcg_sel_none = 2'h3
    } pcg_sel_t;

    // ------------------------------------------------------------
    // Whole state of the register block
    // ------------------------------------------------------------
    typedef struct packed {
        pcg_wr_t wr;          // Write progress
        pcg_sel_t wsel;       // Held write target
        logic [31:0] wdata;   // Held write data
        logic [3:0] wstrb;    // Held byte strobes
        logic aw_rdy;         // Write address ready
        logic w_rdy;          // Write data ready
        logic b_valid;        // Write response valid
        logic [1:0] b_resp;   // Write response code
        pcg_rd_t rd;          // Read progress
        logic ar_rdy;         // Read address ready
        logic r_valid;        // Read data valid
        logic [31:0] r_data;  // Read data
        logic [1:0] r_resp;   // Read response code
        logic [31:0] reg_a;   // Enable register A
        logic [31:0] reg_b;   // Enable register B
    } pcg_regs_state_t;

endpackage : pcg_pkg

// >>> design/pcg_regs.sv
// Summary of operation
// RULE1: A bit 18 gates timer D clock
// RULE2: A bit 17 gates USB device clock
// RULE3: A bit 16 gates converter; resets one
// RULE4: A bit 15 gates DMA clock
// RULE5: A bit 14 gates sync serial clock
// RULE6: A bit 13 gates serial 0 clock
// RULE7: A bit 12 gates I2C 0 clock
// RULE8: A bit 11 gates 16-bit timer clock
// RULE9: A bit 10 gates timer channels 4-6
// RULE10: A bit 9 gates timer channels 0-3
// RULE11: A bit 8 gates port J clock
// RULE12: A bit 7 gates port H clock
// RULE13: B bit 31 gates I2C 1 clock
// RULE14: B bit 30 gates watchdog clock
// RULE15: B bit 29 gates serial 1 clock
// RULE16: B bit 28 gates timer channel 7
// RULE17: All clocks run while reset held
// RULE18: Unused bits stored, written zero, ignored
// RULE19: Glitch-free switching within few cycles
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

`include "pcg_map.svh"

module pcg_regs import pcg_pkg::*; #(
    parameter int ADDR_W = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic timer_d_clock_on,
    output logic usb_device_clock_on,
    output logic converter_clock_on,
    output logic dma_clock_on,
    output logic sync_serial_clock_on,
    output logic serial0_clock_on,
    output logic i2c0_clock_on,
    output logic timer16_clock_on,
    output logic timer_ch4_6_clock_on,
    output logic timer_ch0_3_clock_on,
    output logic port_j_clock_on,
    output logic port_h_clock_on,
    output logic i2c1_clock_on,
    output logic watchdog_clock_on,
    output logic serial1_clock_on,
    output logic timer_ch7_clock_on
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("pcg_regs needs an address width of 4 to 32");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int GATES = 16;  // Gated peripheral clocks

    // State after reset
    localparam pcg_regs_state_t RST_ST = '{
        wr: pcg_wr_idle,
        wsel: pcg_sel_none,
        wdata: 32'h0000_0000,
        wstrb: 4'h0,
        aw_rdy: 1'b1,
        w_rdy: 1'b1,
        b_valid: 1'b0,
        b_resp: `PCG_RESP_OKAY,
        rd: pcg_rd_idle,
        ar_rdy: 1'b1,
        r_valid: 1'b0,
        r_data: 32'h0000_0000,
        r_resp: `PCG_RESP_OKAY,
        reg_a: `PCG_RST_ENABLE_A,
        reg_b: `PCG_RST_ENABLE_B
    };

    pcg_regs_state_t st;       // Current state
    pcg_regs_state_t next_st;  // Next state
    logic aw_hs;               // Write address taken
    logic w_hs;                // Write data taken
    logic do_wr;               // Register write this cycle
    pcg_sel_t wr_sel;          // Target of that write
    logic [31:0] wr_data;      // Data of that write
    logic [3:0] wr_strb;       // Strobes of that write
    logic [GATES-1:0] req;     // Requested enables
    logic [GATES-1:0] gate_on; // Enables in force

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Map a bus address onto a register, ignoring byte lane bits
    function automatic pcg_sel_t pcg_decode(input logic [ADDR_W-1:0] addr);
        logic [31:0] word;
        word = {{(32-ADDR_W){1'b0}}, addr[ADDR_W-1:2], 2'b00};
        if (word == `PCG_OFF_ENABLE_A) begin
            return pcg_sel_a;
        end else if (word == `PCG_OFF_ENABLE_B) begin
            return pcg_sel_b;
        end else if (word == `PCG_OFF_LIVE) begin
            return pcg_sel_live;
        end
        return pcg_sel_none;
    endfunction : pcg_decode

    // Merge written bytes into an old value
    function automatic logic [31:0] pcg_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] mask;  // Byte lanes being written
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~mask) | (data & mask);
    endfunction : pcg_merge

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    assign aw_hs = awvalid && st.aw_rdy;
    assign w_hs = wvalid && st.w_rdy;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        do_wr = 1'b0;
        wr_sel = st.wsel;
        wr_data = st.wdata;
        wr_strb = st.wstrb;
        // Write channel: address and data in either order
        unique case (st.wr)
            pcg_wr_idle: begin
                if (aw_hs && w_hs) begin
                    do_wr = 1'b1;
                    wr_sel = pcg_decode(awaddr);
                    wr_data = wdata;
                    wr_strb = wstrb;
                end else if (aw_hs) begin
                    // Address first, hold it
                    next_st.wsel = pcg_decode(awaddr);
                    next_st.wr = pcg_wr_addr;
                end else if (w_hs) begin
                    // Data first, hold it
                    next_st.wdata = wdata;
                    next_st.wstrb = wstrb;
                    next_st.wr = pcg_wr_data;
                end
            end
            pcg_wr_addr: begin
                if (w_hs) begin
                    do_wr = 1'b1;
                    wr_data = wdata;
                    wr_strb = wstrb;
                end
            end
            pcg_wr_data: begin
                if (aw_hs) begin
                    do_wr = 1'b1;
                    wr_sel = pcg_decode(awaddr);
                end
            end
            pcg_wr_resp: begin
                // Response held until taken
                if (bready) begin
                    next_st.wr = pcg_wr_idle;
                end
            end
        endcase
        // Register update and response code
        if (do_wr) begin
            next_st.wr = pcg_wr_resp;
            next_st.b_resp = `PCG_RESP_OKAY;
            // RULE18 unused bits stored
            unique case (wr_sel)
                pcg_sel_a: begin
                    next_st.reg_a = pcg_merge(st.reg_a, wr_data, wr_strb);
                end
                pcg_sel_b: begin
                    next_st.reg_b = pcg_merge(st.reg_b, wr_data, wr_strb);
                end
                pcg_sel_live: begin
                    // Live view is read only
                    next_st.b_resp = `PCG_RESP_SLVERR;
                end
                pcg_sel_none: begin
                    next_st.b_resp = `PCG_RESP_SLVERR;
                end
            endcase
        end
        next_st.aw_rdy = (next_st.wr == pcg_wr_idle) || (next_st.wr == pcg_wr_data);
        next_st.w_rdy = (next_st.wr == pcg_wr_idle) || (next_st.wr == pcg_wr_addr);
        next_st.b_valid = (next_st.wr == pcg_wr_resp);
        // Read channel
        unique case (st.rd)
            pcg_rd_idle: begin
                if (arvalid) begin
                    next_st.rd = pcg_rd_data;
                    next_st.r_resp = `PCG_RESP_OKAY;
                    unique case (pcg_decode(araddr))
                        pcg_sel_a: begin
                            next_st.r_data = st.reg_a;
                        end
                        pcg_sel_b: begin
                            next_st.r_data = st.reg_b;
                        end
                        pcg_sel_live: begin
                            next_st.r_data = {{(32-GATES){1'b0}}, gate_on};
                        end
                        pcg_sel_none: begin
                            next_st.r_data = 32'h0000_0000;
                            next_st.r_resp = `PCG_RESP_SLVERR;
                        end
                    endcase
                end
            end
            pcg_rd_data: begin
                // Data held until taken
                if (rready) begin
                    next_st.rd = pcg_rd_idle;
                end
            end
        endcase
        next_st.ar_rdy = (next_st.rd == pcg_rd_idle);
        next_st.r_valid = (next_st.rd == pcg_rd_data);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Clock gates
    // ------------------------------------------------------------
    // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8 bit mapping
    // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE16 bit mapping
    assign req = {
        st.reg_a[`PCG_BIT_TIMER_D], st.reg_a[`PCG_BIT_USB_DEVICE],
        st.reg_a[`PCG_BIT_CONVERTER], st.reg_a[`PCG_BIT_DMA],
        st.reg_a[`PCG_BIT_SYNC_SERIAL], st.reg_a[`PCG_BIT_SERIAL0],
        st.reg_a[`PCG_BIT_I2C0], st.reg_a[`PCG_BIT_TIMER16],
        st.reg_a[`PCG_BIT_TIMER_CH4_6], st.reg_a[`PCG_BIT_TIMER_CH0_3],
        st.reg_a[`PCG_BIT_PORT_J], st.reg_a[`PCG_BIT_PORT_H],
        st.reg_b[`PCG_BIT_I2C1], st.reg_b[`PCG_BIT_WATCHDOG],
        st.reg_b[`PCG_BIT_SERIAL1], st.reg_b[`PCG_BIT_TIMER_CH7]
    };

    // RULE17 RULE19 forced on, edge aligned
    pcg_gate_bank #(
        .N(GATES)
    ) u_gate_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .req(req),
        .gate_on(gate_on)
    );

    assign {
        timer_d_clock_on, usb_device_clock_on, converter_clock_on,
        dma_clock_on, sync_serial_clock_on, serial0_clock_on,
        i2c0_clock_on, timer16_clock_on, timer_ch4_6_clock_on,
        timer_ch0_3_clock_on, port_j_clock_on, port_h_clock_on,
        i2c1_clock_on, watchdog_clock_on, serial1_clock_on,
        timer_ch7_clock_on
    } = gate_on;

    // ------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------
    assign awready = st.aw_rdy;
    assign wready = st.w_rdy;
    assign bvalid = st.b_valid;
    assign bresp = st.b_resp;
    assign arready = st.ar_rdy;
    assign rvalid = st.r_valid;
    assign rdata = st.r_data;
    assign rresp = st.r_resp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Gate follows its enable bit one edge later
    property p_follow(logic g, logic b);
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> g == $past(b);
    endproperty

    timer_d_gate_a: assert property (p_follow(timer_d_clock_on, st.reg_a[18])) // RULE1
        else $error("timer d clock does not follow its enable");
    usb_gate_a: assert property (p_follow(usb_device_clock_on, st.reg_a[17])) // RULE2
        else $error("usb clock does not follow its enable");
    converter_gate_a: assert property (p_follow(converter_clock_on, st.reg_a[16])) // RULE3
        else $error("converter clock does not follow its enable");
    dma_gate_a: assert property (p_follow(dma_clock_on, st.reg_a[15])) // RULE4
        else $error("dma clock does not follow its enable");
    sync_serial_gate_a: assert property (p_follow(sync_serial_clock_on, st.reg_a[14])) // RULE5
        else $error("sync serial clock does not follow its enable");
    serial0_gate_a: assert property (p_follow(serial0_clock_on, st.reg_a[13])) // RULE6
        else $error("serial 0 clock does not follow its enable");
    i2c0_gate_a: assert property (p_follow(i2c0_clock_on, st.reg_a[12])) // RULE7
        else $error("i2c 0 clock does not follow its enable");
    timer16_gate_a: assert property (p_follow(timer16_clock_on, st.reg_a[11])) // RULE8
        else $error("16-bit timer clock does not follow its enable");
    ch4_6_gate_a: assert property (p_follow(timer_ch4_6_clock_on, st.reg_a[10])) // RULE9
        else $error("timer ch4-6 clock does not follow its enable");
    ch0_3_gate_a: assert property (p_follow(timer_ch0_3_clock_on, st.reg_a[9])) // RULE10
        else $error("timer ch0-3 clock does not follow its enable");
    port_j_gate_a: assert property (p_follow(port_j_clock_on, st.reg_a[8])) // RULE11
        else $error("port j clock does not follow its enable");
    port_h_gate_a: assert property (p_follow(port_h_clock_on, st.reg_a[7])) // RULE12
        else $error("port h clock does not follow its enable");
    i2c1_gate_a: assert property (p_follow(i2c1_clock_on, st.reg_b[31])) // RULE13
        else $error("i2c 1 clock does not follow its enable");
    watchdog_gate_a: assert property (p_follow(watchdog_clock_on, st.reg_b[30])) // RULE14
        else $error("watchdog clock does not follow its enable");
    serial1_gate_a: assert property (p_follow(serial1_clock_on, st.reg_b[29])) // RULE15
        else $error("serial 1 clock does not follow its enable");
    ch7_gate_a: assert property (p_follow(timer_ch7_clock_on, st.reg_b[28])) // RULE16
        else $error("timer ch7 clock does not follow its enable");

    // All gates open at release, registers at reset values
    reset_gates_on_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        !$past(aresetn) |-> (&gate_on) && st.reg_a == 32'h0001_0001
            && st.reg_b == 32'hf000_0000)
        else $error("gates or enables wrong just after reset");

    // Unused bits stored but never move a gate
    unused_bits_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
        $past(aresetn) && $past(aresetn, 2) && $past(req) == $past(req, 2)
        |-> $stable(gate_on))
        else $error("gate moved without its enable changing");

    // A full write to A reaches the gates two edges after it is taken
    write_latency_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
        st.wr == pcg_wr_idle && aw_hs && w_hs && pcg_decode(awaddr) == pcg_sel_a
            && wstrb == 4'hf
        |-> ##2 timer_d_clock_on == $past(wdata[18], 2))
        else $error("enable write did not reach gate in two cycles");

    // Response held until taken
    bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    // Unmapped read answers with error and zero data
    unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && pcg_decode(araddr) == pcg_sel_none
        |=> rvalid && rresp == 2'h2 && rdata == 32'h0000_0000)
        else $error("unmapped read not answered with error");

    // Main scenarios
    write_a_c: cover property (@(posedge aclk) disable iff (!aresetn)
        do_wr && wr_sel == pcg_sel_a);
    write_split_c: cover property (@(posedge aclk) disable iff (!aresetn)
        st.wr == pcg_wr_data ##1 bvalid);
    read_b_c: cover property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && pcg_decode(araddr) == pcg_sel_b);
    gate_off_c: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(watchdog_clock_on));

endmodule : pcg_regs

// >>> test/pcg_periph_model.sv
`timescale 1ns/1ps

module pcg_periph_model import pcg_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] gate_on,
    output logic [15:0] tick
);
    // Each peripheral flips its state only on cycles its clock is supplied;
    // system reset clears every peripheral so no unknown lingers
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 16'h0000;
        end else begin
            tick <= tick ^ gate_on;
        end
    end
endmodule : pcg_periph_model

// >>> test/tb_peripheral_clock_gating.sv
`timescale 1ns/1ps

module tb_peripheral_clock_gating import pcg_pkg::*;;
    // --------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] prot = 3'h0;
    logic awready, wready, arready, bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, a, b;
    wire [15:0] g;  // Gate outputs, timer_d at bit 15
    logic [15:0] tick;
    int fail_count = 0;
    int checks = 0;
    int i;

    // Bus clock, 40 ns period
    always #20 aclk = ~aclk;

    pcg_regs dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(prot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .timer_d_clock_on(g[15]),
        .usb_device_clock_on(g[14]), .converter_clock_on(g[13]), .dma_clock_on(g[12]),
        .sync_serial_clock_on(g[11]), .serial0_clock_on(g[10]), .i2c0_clock_on(g[9]),
        .timer16_clock_on(g[8]), .timer_ch4_6_clock_on(g[7]), .timer_ch0_3_clock_on(g[6]),
        .port_j_clock_on(g[5]), .port_h_clock_on(g[4]), .i2c1_clock_on(g[3]),
        .watchdog_clock_on(g[2]), .serial1_clock_on(g[1]), .timer_ch7_clock_on(g[0]));

    // Peripherals fed by the gated clocks
    pcg_periph_model periph_u (.aclk(aclk), .aresetn(aresetn), .gate_on(g), .tick(tick));

    // --------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp

    // A wait that used its whole bound ends the run
    task automatic tmo(input int n);
        if (n >= 20) begin
            fail_count++;
            final_report();
        end
    endtask : tmo

    task automatic wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        tmo(n);
        bready <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr

    task automatic rd(input logic [3:0] ad, input logic [31:0] ex, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        tmo(n);
        rready <= 1'b0;
        cmp("rdata", ex, rdata);
        cmp("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd

    // Gates follow the enable bits, and only supplied peripherals advance
    task automatic gchk(input logic [31:0] ea, input logic [31:0] eb);
        logic [15:0] t0;
        @(posedge aclk);
        #1;
        t0 = tick;
        cmp("gates", {16'h0, ea[18:7], eb[31:28]}, {16'h0, g});
        @(posedge aclk);
        #1;
        cmp("ticks", {16'h0, t0 ^ {ea[18:7], eb[31:28]}}, {16'h0, tick});
    endtask : gchk

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        repeat (2) @(posedge aclk);
        #1;
        cmp("reset gates", 32'h0000ffff, {16'h0, g});
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h00010001, 2'h0);
        rd(4'h4, 32'hf0000000, 2'h0);
        gchk(32'h00010001, 32'hf0000000);
        $display("test reset values done");
        // One enable at a time, across both registers
        for (i = 0; i < 16; i++) begin
            a = (i < 12) ? (32'h1 << (18 - i)) : 32'h0;
            b = (i < 12) ? 32'h0 : (32'h1 << (43 - i));
            wr(4'h0, a, 4'hf, 2'h0);
            wr(4'h4, b, 4'hf, 2'h0);
            gchk(a, b);
            rd(4'h8, {16'h0, a[18:7], b[31:28]}, 2'h0);
        end
        $display("test single enables done");
        wr(4'h0, 32'hfff8007f, 4'hf, 2'h0);
        wr(4'h4, 32'h0fffffff, 4'hf, 2'h0);
        gchk(32'h0, 32'h0);
        rd(4'h0, 32'hfff8007f, 2'h0);
        wr(4'h0, 32'hffffffff, 4'h4, 2'h0);
        rd(4'h0, 32'hffff007f, 2'h0);
        gchk(32'h00070000, 32'h0);
        $display("test spare bits and strobes done");
        wr(4'hc, 32'hffffffff, 4'hf, 2'h2);
        wr(4'h8, 32'hffffffff, 4'hf, 2'h2);
        rd(4'hc, 32'h0, 2'h2);
        rd(4'h0, 32'hffff007f, 2'h0);
        rd(4'h4, 32'h0fffffff, 2'h0);
        $display("test refused accesses done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        cmp("mid reset gates", 32'h0000ffff, {16'h0, g});
        @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h00010001, 2'h0);
        gchk(32'h00010001, 32'hf0000000);
        $display("test second reset done");
        final_report();
    end
endmodule : tb_peripheral_clock_gating
